/* File: design/sdr_map.svh */
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH
`define SDR_OFF_RESP_BASE 8'h00
`define SDR_OFF_RESP_LAST 8'h1c
`define SDR_OFF_INDEX 8'h20
`define SDR_OFF_CRC_STATUS 8'h24
`define SDR_OFF_RW_CONTROL 8'h28
`define SDR_OFF_STATUS0 8'h2c
`define SDR_OFF_IRQ_ENABLE 8'h30
`define SDR_OFF_IRQ_FLAGS 8'h34
`define SDR_OFF_IRQ_CLEAR 8'h38
`define SDR_RWC_REQ 0
`define SDR_RWC_CRC 1
`define SDR_ST_DATA_LINE1_LEVEL 0
`define SDR_ST_PERIOD 1
`define SDR_ST_RW_ACTIVE 2
`define SDR_IRQ_CARD 0
`define SDR_IRQ_RW 1
`define SDR_LONG_IDX_LO 128
`define SDR_SHORT_IDX_LO 40
`define SDR_SLICE_W 16
`define SDR_RST_RWC 1'b0
`define SDR_RST_IEN 2'h0
`define SDR_RST_FLAGS 2'h0
`define SDR_RST_WORD 16'h0000
`define SDR_RST_BYTE 8'h00
`define SDR_RW_DELAY_EDGES 2'h2
`define SDR_RESP_OKAY 2'h0
`define SDR_RESP_SLVERR 2'h2
`endif

/* File: design/sdr_pkg.sv */
package sdr_pkg;
    typedef struct packed {
        logic valid;
        logic is_long;
        logic [135:0] bits;
    } sdr_resp_s;

    typedef struct packed {
        logic valid;
        logic [7:0] token;
    } sdr_token_s;

    typedef struct packed {
        logic block_end;
        logic crc_error;
        logic multi_block;
        logic last_block;
    } sdr_read_evt_s;

    typedef enum logic [1:0] {
        SDR_RW_IDLE = 2'b00,
        SDR_RW_ARMED = 2'b01,
        SDR_RW_DELAY = 2'b10,
        SDR_RW_ACTIVE = 2'b11
    } sdr_rw_state_e;
endpackage

/* File: design/sdr_response_read_wait.sv */
// How it works
// - Long response slices fill index and eight words.
// - Card CRC token kept in low byte.
// - First response byte goes to index register.
// - Read wait starts two clocks after block end.
// - Clearing request ends wait, releases data line 2.
// - CRC error mid multi-block read starts wait.
// - Status bit 2 shows read wait active.
// - Status bit 1 shows card interrupt period.
// - Status bit 0 shows data line 1 level.
// - Read wait start sets flag when enabled.
// - Card interrupt sets flag when enabled.
// - Flags clear only on written ones.
// - Enable bit 1 read wait, bit 0 card.
// - Every response overwrites the index register; only long ones overwrite the eight words.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`include "sdr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sdr_response_read_wait
    import sdr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sdr_resp_s resp_in,
    input wire sdr_token_s token_in,
    input wire sdr_read_evt_s read_evt,
    input wire logic card_irq_period,
    input wire logic sd_clk,
    input wire logic card_data_line1_pin,
    output logic data_line2_out,
    output logic data_line2_oe,
    output logic irq
);
    logic [15:0] response_word [8];
    logic [7:0] index_byte_reg;
    logic [7:0] crc_token_field;
    logic read_wait_request;
    logic wait_on_crc_error_en;
    logic read_wait_irq_en;
    logic card_irq_en;
    logic [1:0] irq_flags;
    sdr_rw_state_e rw_state;
    logic [1:0] rw_edges;
    logic clk_meta, clk_sync, clk_prev;
    logic data_line1_level_meta, data_line1_level;
    logic period_q;

    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_lo;
    logic [ADDR_W-1:0] wr_off;
    logic wr_mapped;
    logic [31:0] rd_data;
    logic rd_mapped;

    logic sd_rise;
    logic auto_start;
    logic rw_start;
    logic card_event;
    logic [1:0] clr_bits;
    logic [1:0] set_bits;

    // The link clock is only sampled here; its edges pace the read wait delay.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            clk_meta <= sd_clk;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
        end
    end

    assign sd_rise = clk_sync && !clk_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_line1_level_meta <= 1'b1;
            data_line1_level <= 1'b1;
        end else begin
            data_line1_level_meta <= card_data_line1_pin;
            data_line1_level <= data_line1_level_meta;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= 1'b0;
        end else begin
            period_q <= card_irq_period;
        end
    end

    // A low data line 1 inside the period is the card asking for service.
    assign card_event = period_q && !data_line1_level;

    // Responses overwrite regardless of whether software has read them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_byte_reg <= `SDR_RST_BYTE;
            for (int i = 0; i < 8; i++) begin
                response_word[i] <= `SDR_RST_WORD;
            end
        end else if (resp_in.valid) begin
            if (resp_in.is_long) begin
                index_byte_reg <= resp_in.bits[`SDR_LONG_IDX_LO +: 8];
                for (int i = 0; i < 8; i++) begin
                    response_word[i] <= resp_in.bits[i*`SDR_SLICE_W +: `SDR_SLICE_W];
                end
            end else begin
                index_byte_reg <= resp_in.bits[`SDR_SHORT_IDX_LO +: 8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_token_field <= `SDR_RST_BYTE;
        end else if (token_in.valid) begin
            crc_token_field <= token_in.token;
        end
    end

    // Bus slave: address and data are taken independently, then committed together.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_held) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_held) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_off = {aw_addr[ADDR_W-1:2], 2'b00};
    assign wr_lo = wr_fire && w_strb[0];

    always_comb begin
        case (wr_off)
            `SDR_OFF_INDEX, `SDR_OFF_CRC_STATUS, `SDR_OFF_RW_CONTROL, `SDR_OFF_STATUS0,
            `SDR_OFF_IRQ_ENABLE, `SDR_OFF_IRQ_FLAGS, `SDR_OFF_IRQ_CLEAR: wr_mapped = 1'b1;
            default: wr_mapped = (wr_off <= `SDR_OFF_RESP_LAST);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `SDR_RESP_OKAY : `SDR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A CRC error on any block but the last, with the enable set, starts wait alone.
    assign auto_start = wait_on_crc_error_en && read_evt.crc_error
                        && read_evt.multi_block && !read_evt.last_block;

    // Hardware setting the request wins over a software write in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_wait_request <= `SDR_RST_RWC;
            wait_on_crc_error_en <= `SDR_RST_RWC;
        end else begin
            if (auto_start) begin
                read_wait_request <= 1'b1;
            end else if (wr_lo && wr_off == `SDR_OFF_RW_CONTROL) begin
                read_wait_request <= w_data[`SDR_RWC_REQ];
            end
            if (wr_lo && wr_off == `SDR_OFF_RW_CONTROL) begin
                wait_on_crc_error_en <= w_data[`SDR_RWC_CRC];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {read_wait_irq_en, card_irq_en} <= `SDR_RST_IEN;
        end else if (wr_lo && wr_off == `SDR_OFF_IRQ_ENABLE) begin
            read_wait_irq_en <= w_data[`SDR_IRQ_RW];
            card_irq_en <= w_data[`SDR_IRQ_CARD];
        end
    end

    // Delay edges are counted on the sampled link clock, not on aclk.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rw_state <= SDR_RW_IDLE;
            rw_edges <= 2'h0;
        end else if (!read_wait_request && !auto_start) begin
            rw_state <= SDR_RW_IDLE;
            rw_edges <= 2'h0;
        end else begin
            case (rw_state)
                SDR_RW_IDLE: begin
                    rw_edges <= 2'h0;
                    rw_state <= auto_start ? SDR_RW_DELAY : SDR_RW_ARMED;
                end
                SDR_RW_ARMED: begin
                    rw_edges <= 2'h0;
                    if (read_evt.block_end || auto_start) begin
                        rw_state <= SDR_RW_DELAY;
                    end
                end
                SDR_RW_DELAY: begin
                    if (sd_rise) begin
                        rw_edges <= rw_edges + 2'h1;
                        if (rw_edges + 2'h1 == `SDR_RW_DELAY_EDGES) begin
                            rw_state <= SDR_RW_ACTIVE;
                        end
                    end
                end
                SDR_RW_ACTIVE: begin
                    rw_state <= SDR_RW_ACTIVE;
                end
                default: begin
                    rw_state <= SDR_RW_IDLE;
                end
            endcase
        end
    end

    assign rw_start = (rw_state == SDR_RW_DELAY) && sd_rise && read_wait_request
                      && (rw_edges + 2'h1 == `SDR_RW_DELAY_EDGES);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_line2_oe <= 1'b0;
            data_line2_out <= 1'b1;
        end else begin
            data_line2_oe <= rw_start || (rw_state == SDR_RW_ACTIVE && read_wait_request);
            data_line2_out <= !(rw_start || (rw_state == SDR_RW_ACTIVE && read_wait_request));
        end
    end

    assign set_bits[`SDR_IRQ_RW] = rw_start && read_wait_irq_en;
    assign set_bits[`SDR_IRQ_CARD] = card_event && card_irq_en;
    assign clr_bits = (wr_lo && (wr_off == `SDR_OFF_IRQ_FLAGS || wr_off == `SDR_OFF_IRQ_CLEAR))
                      ? w_data[1:0] : 2'h0;

    // Sticky flags: a written one clears, a zero leaves alone, a new event wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flags <= `SDR_RST_FLAGS;
        end else begin
            irq_flags <= (irq_flags & ~clr_bits) | set_bits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_flags & {read_wait_irq_en, card_irq_en});
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_mapped = 1'b1;
        case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            `SDR_OFF_INDEX: rd_data[7:0] = index_byte_reg;
            `SDR_OFF_CRC_STATUS: rd_data[7:0] = crc_token_field;
            `SDR_OFF_RW_CONTROL: rd_data[1:0] = {wait_on_crc_error_en, read_wait_request};
            `SDR_OFF_STATUS0: begin
                rd_data[`SDR_ST_RW_ACTIVE] = (rw_state == SDR_RW_ACTIVE);
                rd_data[`SDR_ST_PERIOD] = period_q;
                rd_data[`SDR_ST_DATA_LINE1_LEVEL] = data_line1_level;
            end
            `SDR_OFF_IRQ_ENABLE: rd_data[1:0] = {read_wait_irq_en, card_irq_en};
            `SDR_OFF_IRQ_FLAGS: rd_data[1:0] = irq_flags;
            `SDR_OFF_IRQ_CLEAR: rd_data = 32'h0000_0000;
            default: begin
                if ({s_axi_araddr[ADDR_W-1:2], 2'b00} <= `SDR_OFF_RESP_LAST) begin
                    rd_data[15:0] = response_word[s_axi_araddr[4:2]];
                end else begin
                    rd_mapped = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SDR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_mapped ? `SDR_RESP_OKAY : `SDR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: test/sdr_rrw_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_rrw_props
    import sdr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_bvalid,
    input wire sdr_read_evt_s read_evt,
    input wire logic data_line2_out,
    input wire logic data_line2_oe,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_t;
    logic quiet;
    assign ar_t = s_axi_arvalid && s_axi_arready;
    assign quiet = !s_axi_awvalid && !s_axi_bvalid;
    a_drive_low: assert property (data_line2_oe |-> !data_line2_out)
        else $error("data line 2 enabled while high");
    a_wait_delay: assert property (read_evt.block_end && !data_line2_oe |=> !data_line2_oe [*3])
        else $error("read wait began too soon after block end");
    a_wait_holds: assert property (data_line2_oe && quiet && !$past(s_axi_awvalid) |=> data_line2_oe)
        else $error("read wait dropped without a write");
    a_release_cause: assert property ($fell(data_line2_oe) |-> $past(s_axi_bvalid) || $past(s_axi_awvalid, 2))
        else $error("data line 2 released with no write");
    a_status_on: assert property (ar_t && s_axi_araddr == 8'h2c && data_line2_oe ##1 data_line2_oe
        |-> s_axi_rdata[2])
        else $error("status shows no read wait while waiting");
    a_status_off: assert property (ar_t && s_axi_araddr == 8'h2c && !data_line2_oe && !$past(data_line2_oe)
        ##1 !data_line2_oe |-> !s_axi_rdata[2])
        else $error("status shows read wait while idle");
    a_irq_sticky: assert property (irq && quiet && !$past(s_axi_awvalid) |=> irq)
        else $error("interrupt dropped without a write");
    a_crc_reserved: assert property (ar_t && s_axi_araddr == 8'h24 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("crc status upper bits not zero");
    a_index_reserved: assert property (ar_t && s_axi_araddr == 8'h20 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("index upper bits not zero");
endmodule
bind sdr_response_read_wait sdr_rrw_props #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_awvalid, .s_axi_bvalid, .read_evt,
    .data_line2_out, .data_line2_oe, .irq);
`default_nettype wire

/* File: test/sdr_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_card_model (
    input wire logic run,
    input wire logic line1,
    output logic sd_clk,
    output logic card_data_line1_pin
);
    // The link clock stands still between frames, so a design that needs no edges cannot pass.
    initial begin
        sd_clk = 1'b0;
        #7;
        forever #160 sd_clk = run ? ~sd_clk : 1'b0;
    end
    assign card_data_line1_pin = line1;
endmodule
`default_nettype wire

/* File: test/sdr_response_read_wait_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_response_read_wait_test
    import sdr_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    sdr_resp_s resp_in = '0;
    sdr_token_s token_in = '0;
    sdr_read_evt_s read_evt = '0;
    logic card_irq_period = 1'b0, run = 1'b0, line1 = 1'b1;
    logic sd_clk, card_data_line1_pin, data_line2_out, data_line2_oe, irq;
    logic [135:0] lb;
    int n_fail = 0, tests_run = 0, cyc = 0;
    always #20 aclk = ~aclk;
    sdr_card_model u_card (.run(run), .line1(line1), .sd_clk(sd_clk), .card_data_line1_pin(card_data_line1_pin));
    sdr_response_read_wait #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .resp_in(resp_in), .token_in(token_in),
        .read_evt(read_evt), .card_irq_period(card_irq_period), .sd_clk(sd_clk),
        .card_data_line1_pin(card_data_line1_pin), .data_line2_out(data_line2_out),
        .data_line2_oe(data_line2_oe), .irq(irq));
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        wr_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check(rd_d, e);
    endtask
    task automatic pulse_evt(input logic [3:0] e);
        @(posedge aclk);
        read_evt <= e;
        @(posedge aclk);
        read_evt <= {2'b00, e[1:0]};
    endtask
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (data_line2_oe !== v && n < 200) begin
            @(posedge aclk);
            n++;
        end
        check({31'h0, data_line2_oe}, {31'h0, v});
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 16; i++) begin
            rd_chk(8'(4 * i), (i == 11) ? 32'h1 : 32'h0);
        end
        check({30'h0, rd_r}, 32'h2);
        axi_write(8'h3c, 32'h1);
        check({30'h0, wr_r}, 32'h2);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) begin
                lb[16 * i +: 16] = 16'(16'h1111 * i + 16'h0f00 * k);
            end
            lb[135:128] = 8'(8'h3f + k);
            @(posedge aclk);
            resp_in <= {1'b1, 1'b1, lb};
            @(posedge aclk);
            resp_in.valid <= 1'b0;
            rd_chk(8'h20, {24'h0, lb[135:128]});
            for (int i = 0; i < 8; i++) begin
                rd_chk(8'(4 * i), {16'h0, lb[16 * i +: 16]});
            end
        end
        @(posedge aclk);
        resp_in <= {1'b1, 1'b0, 88'h0, 8'h3e, 40'h0};
        token_in <= {1'b1, 8'he5};
        @(posedge aclk);
        resp_in.valid <= 1'b0;
        token_in.valid <= 1'b0;
        rd_chk(8'h20, 32'h3e);
        axi_write(8'h24, 32'hff);
        check({30'h0, wr_r}, 32'h0);
        rd_chk(8'h24, 32'he5);
        axi_write(8'h30, 32'h2);
        axi_write(8'h28, 32'h1);
        repeat (10) @(posedge aclk);
        check({31'h0, data_line2_oe}, 32'h0);
        run <= 1'b1;
        pulse_evt(4'b1000);
        wait_oe(1'b1);
        check({30'h0, data_line2_oe, data_line2_out}, 32'h2);
        run <= 1'b0;
        rd_chk(8'h2c, 32'h5);
        rd_chk(8'h34, 32'h2);
        check({31'h0, irq}, 32'h1);
        axi_write(8'h34, 32'h1);
        rd_chk(8'h34, 32'h2);
        axi_write(8'h34, 32'h2);
        rd_chk(8'h34, 32'h0);
        check({30'h0, irq, data_line2_oe}, 32'h1);
        axi_write(8'h28, 32'h0);
        wait_oe(1'b0);
        check({30'h0, data_line2_oe, data_line2_out}, 32'h1);
        rd_chk(8'h2c, 32'h1);
        axi_write(8'h28, 32'h2);
        run <= 1'b1;
        pulse_evt(4'b0111);
        repeat (40) @(posedge aclk);
        rd_chk(8'h28, 32'h2);
        pulse_evt(4'b0110);
        wait_oe(1'b1);
        rd_chk(8'h28, 32'h3);
        axi_write(8'h28, 32'h2);
        wait_oe(1'b0);
        run <= 1'b0;
        axi_write(8'h38, 32'h3);
        rd_chk(8'h34, 32'h0);
        axi_write(8'h30, 32'h1);
        line1 <= 1'b0;
        card_irq_period <= 1'b1;
        // The pin passes two flops, so give it time to reach the status register.
        repeat (2) @(posedge aclk);
        rd_chk(8'h2c, 32'h2);
        rd_chk(8'h34, 32'h1);
        check({31'h0, irq}, 32'h1);
        card_irq_period <= 1'b0;
        line1 <= 1'b1;
        axi_write(8'h30, 32'h0);
        axi_write(8'h34, 32'h1);
        card_irq_period <= 1'b1;
        line1 <= 1'b0;
        repeat (2) @(posedge aclk);
        rd_chk(8'h34, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
